/* File: logic/adcr_regs.v */
// adcr_regs.v: serial-port register bank of the dual converter, with the
// test pattern / offset trim datapath, link sync error monitor, link soft
// resets and quick setup decode.
// assumes: serial clock well below core_clk_i/4; converter samples arrive
// on core_clk_i with sample_en_i; link logic takes the decoded settings.
`timescale 1ns/1ps
`include "adcr_consts.vh"

module adcr_regs (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        rst_i,
    // serial configuration port
    input  wire        spi_sclk_i,
    input  wire        spi_cs_n_i,
    input  wire        spi_sdio_i,
    output wire        spi_sdio_o,
    output wire        spi_sdio_oe_o,
    // configuration pins and link sync pin
    input  wire [3:0]  cfg_pins_i,
    input  wire        link_sync_i,
    // converter samples
    input  wire        sample_en_i,
    input  wire [11:0] adc_a_data_i,
    input  wire [11:0] adc_b_data_i,
    output wire [11:0] out_a_data_o,
    output wire [11:0] out_b_data_o,
    // analog reference settings
    output wire        internal_reference_enable_o,
    output wire [2:0]  reference_attenuation_o,
    // link control
    output wire        link_unit_reset_o,
    output wire        link_fsm_reset_o,
    output wire        sync_single_ended_o,
    output wire        conv_a_en_o,
    output wire        conv_b_en_o,
    output wire        lane0_en_o,
    output wire        lane1_en_o,
    output wire [2:0]  octets_per_frame_o,
    output wire        high_density_o,
    output wire [4:0]  frames_per_multi_o,
    output wire [1:0]  converters_o,
    output wire [1:0]  lanes_o,
    output wire        ctrl_bits_o,
    output wire        ctrl_words_o,
    output wire        samples_o,
    output wire        loop_test_o,
    output wire        power_down_o
);

    // serial frame states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_HDR  = 2'b01;
    localparam [1:0] ST_DATA = 2'b10;
    localparam [1:0] ST_DONE = 2'b11;

    // pin synchronisers
    wire [2:0] spi_s;
    wire [4:0] pin_s;
    adcr_sync3 #(.W(3), .RST_VAL(3'b010)) u_spi_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      ({spi_sdio_i, spi_cs_n_i, spi_sclk_i}),
        .sync_o     (spi_s)
    );
    adcr_sync3 #(.W(5), .RST_VAL(5'b00000)) u_pin_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      ({link_sync_i, cfg_pins_i}),
        .sync_o     (pin_s)
    );
    wire sclk_s = spi_s[0];
    wire csn_s  = spi_s[1];
    wire sdi_s  = spi_s[2];

    // register storage
    reg  [3:0]  ref_ctrl_q;
    reg  [5:0]  offset_q;
    reg  [2:0]  pat_sel_q;
    reg  [7:0]  pat_high_q;
    reg  [3:0]  pat_low_q;
    reg         unit_rst_q;
    reg         fsm_rst_q;
    reg  [3:0]  setup_q;
    reg         setup_written_q;
    reg  [1:0]  link_ctrl_q;
    reg         sync_err_q;
    reg         por_flag_q;

    // serial engine state
    reg  [1:0]  st_q;
    reg  [4:0]  bit_cnt_q;
    reg  [15:0] hdr_q;
    reg  [7:0]  data_q;
    reg  [7:0]  rd_shift_q;
    reg         sdo_q;
    reg         sdo_oe_q;
    reg         sclk_prev_q;

    wire        sclk_rise = sclk_s & ~sclk_prev_q;
    wire        sclk_fall = ~sclk_s & sclk_prev_q;
    wire        is_read   = hdr_q[15];
    wire [12:0] addr      = hdr_q[12:0];

    // read mux; unmapped addresses read as zero
    function [7:0] read_byte;
        input [12:0] a;
        begin
            case (a)
                `ADCR_ADDR_REF_CTRL:    read_byte = {4'h0, ref_ctrl_q};
                `ADCR_ADDR_OFFSET_TRIM: read_byte = {2'h0, offset_q};
                `ADCR_ADDR_PAT_SELECT:  read_byte = {5'h00, pat_sel_q};
                `ADCR_ADDR_PAT_HIGH:    read_byte = pat_high_q;
                `ADCR_ADDR_PAT_LOW:     read_byte = {pat_low_q, 4'h0};
                `ADCR_ADDR_LINK_STATUS: read_byte = {sync_err_q,
                    `ADCR_STATUS_RSVD, 2'h0, por_flag_q, 1'b0};
                `ADCR_ADDR_LINK_RESET:  read_byte = {unit_rst_q, 3'h0,
                    fsm_rst_q, 3'h0};
                `ADCR_ADDR_QUICK_SETUP: read_byte = {4'h0, setup_q};
                `ADCR_ADDR_LINK_CTRL:   read_byte = {2'h0, link_ctrl_q,
                    4'h8};
                default:                read_byte = 8'h00;
            endcase
        end
    endfunction

    wire [7:0] rd_byte = read_byte(addr);

    // frame sequencer: header, then one data byte; extra bytes ignored
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q        <= ST_IDLE;
            bit_cnt_q   <= 5'd0;
            hdr_q       <= 16'h0000;
            data_q      <= 8'h00;
            rd_shift_q  <= 8'h00;
            sdo_q       <= 1'b0;
            sdo_oe_q    <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            if (csn_s) begin
                st_q      <= ST_IDLE;
                bit_cnt_q <= 5'd0;
                sdo_oe_q  <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        st_q      <= ST_HDR;
                        bit_cnt_q <= 5'd0;
                    end
                    ST_HDR: begin
                        if (sclk_rise) begin
                            hdr_q     <= {hdr_q[14:0], sdi_s};
                            bit_cnt_q <= bit_cnt_q + 5'd1;
                            if (bit_cnt_q == `ADCR_HDR_BITS - 5'd1)
                                st_q <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (sclk_rise) begin
                            data_q    <= {data_q[6:0], sdi_s};
                            bit_cnt_q <= bit_cnt_q + 5'd1;
                            if (bit_cnt_q == `ADCR_FRAME_BITS - 5'd1)
                                st_q <= ST_DONE;
                        end
                        // read data leaves on falling edges
                        if (sclk_fall && is_read) begin
                            if (bit_cnt_q == `ADCR_HDR_BITS) begin
                                sdo_q      <= rd_byte[7];
                                rd_shift_q <= {rd_byte[6:0], 1'b0};
                                sdo_oe_q   <= 1'b1;
                            end else begin
                                sdo_q      <= rd_shift_q[7];
                                rd_shift_q <= {rd_shift_q[6:0], 1'b0};
                            end
                        end
                    end
                    ST_DONE: begin
                        // release the line after the last data bit
                        if (sclk_fall)
                            sdo_oe_q <= 1'b0;
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // write strobe on the last data bit of a write frame
    wire wr_en = (st_q == ST_DATA) && sclk_rise && !is_read &&
                 (bit_cnt_q == `ADCR_FRAME_BITS - 5'd1);
    wire [7:0] wr_data = {data_q[6:0], sdi_s};
    function hit;
        input [12:0] a;
        begin
            hit = wr_en && (addr == a);
        end
    endfunction

    // writable registers
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_ctrl_q      <= 4'h0;
            offset_q        <= 6'h00;
            pat_sel_q       <= 3'h0;
            pat_high_q      <= `ADCR_RST_BYTE;
            pat_low_q       <= 4'h0;
            setup_q         <= 4'h0;
            setup_written_q <= 1'b0;
            link_ctrl_q     <= 2'h0;
        end else begin
            if (hit(`ADCR_ADDR_REF_CTRL))
                ref_ctrl_q <= wr_data[3:0];
            if (hit(`ADCR_ADDR_OFFSET_TRIM))
                offset_q <= wr_data[5:0];
            if (hit(`ADCR_ADDR_PAT_SELECT))
                pat_sel_q <= wr_data[2:0];
            if (hit(`ADCR_ADDR_PAT_HIGH))
                pat_high_q <= wr_data;
            if (hit(`ADCR_ADDR_PAT_LOW))
                pat_low_q <= wr_data[7:4];
            if (hit(`ADCR_ADDR_QUICK_SETUP)) begin
                setup_q         <= wr_data[3:0];
                setup_written_q <= 1'b1;
            end
            if (hit(`ADCR_ADDR_LINK_CTRL))
                link_ctrl_q <= wr_data[5:4];
        end
    end

    // soft reset bits: one-cycle pulse, then the bit clears itself
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            unit_rst_q <= 1'b0;
            fsm_rst_q  <= 1'b0;
        end else begin
            unit_rst_q <= hit(`ADCR_ADDR_LINK_RESET) &&
                          wr_data[`ADCR_UNIT_RST_BIT];
            fsm_rst_q  <= hit(`ADCR_ADDR_LINK_RESET) &&
                          wr_data[`ADCR_FSM_RST_BIT];
        end
    end
    assign link_unit_reset_o = unit_rst_q;
    assign link_fsm_reset_o  = fsm_rst_q | unit_rst_q;

    // sync monitor: a request after the link came up is an error
    wire sync_input_polarity    = link_ctrl_q[1];
    wire sync_active = sync_input_polarity ? pin_s[4] : ~pin_s[4];
    reg  link_up_q;
    wire sync_err_ev = link_up_q & sync_active;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_up_q  <= 1'b0;
            sync_err_q <= 1'b0;
            por_flag_q <= 1'b1;
        end else begin
            if (link_fsm_reset_o || sync_active)
                link_up_q <= 1'b0;
            else
                link_up_q <= 1'b1;
            // a new error wins over the clearing reset
            if (sync_err_ev)
                sync_err_q <= 1'b1;
            else if (unit_rst_q)
                sync_err_q <= 1'b0;
            if (unit_rst_q)
                por_flag_q <= 1'b0;
        end
    end

    // effective setup: register once written, else the pins
    wire [3:0] setup_eff = setup_written_q ? setup_q : pin_s[3:0];

    // quick setup decode: {a,b,l0,l1,F,HD,K,M,L,loop,pd}
    reg [18:0] cfg_dec;
    always @* begin
        case (setup_eff)
            4'h0:    cfg_dec = {4'b1111, 3'd2, 1'b0, 5'd9, 2'd2, 2'd2,
                                2'b00};
            4'h1:    cfg_dec = {4'b1110, 3'd4, 1'b0, 5'd5, 2'd2, 2'd1,
                                2'b00};
            4'h2:    cfg_dec = {4'b1101, 3'd4, 1'b0, 5'd5, 2'd2, 2'd1,
                                2'b00};
            4'h3:    cfg_dec = {4'b1011, 3'd1, 1'b1, 5'd17, 2'd1, 2'd2,
                                2'b00};
            4'h4:    cfg_dec = {4'b0111, 3'd1, 1'b1, 5'd17, 2'd1, 2'd2,
                                2'b00};
            4'h5:    cfg_dec = {4'b1010, 3'd2, 1'b0, 5'd9, 2'd1, 2'd1,
                                2'b00};
            4'h6:    cfg_dec = {4'b1001, 3'd2, 1'b0, 5'd9, 2'd1, 2'd1,
                                2'b00};
            4'h7:    cfg_dec = {4'b0110, 3'd2, 1'b0, 5'd9, 2'd1, 2'd1,
                                2'b00};
            4'h8:    cfg_dec = {4'b0101, 3'd2, 1'b0, 5'd9, 2'd1, 2'd1,
                                2'b00};
            4'he:    cfg_dec = {4'b1111, 3'd2, 1'b0, 5'd9, 2'd2, 2'd2,
                                2'b10};
            4'hf:    cfg_dec = {4'b0000, 3'd2, 1'b0, 5'd9, 2'd2, 2'd2,
                                2'b01};
            // reserved codes: keep everything off rather than guess
            default: cfg_dec = {4'b0000, 3'd2, 1'b0, 5'd9, 2'd2, 2'd2,
                                2'b00};
        endcase
    end

    // decoded settings registered so the link sees clean levels
    reg [18:0] cfg_q;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i)
            cfg_q <= 19'h00000;
        else
            cfg_q <= cfg_dec;
    end
    assign conv_a_en_o        = cfg_q[18];
    assign conv_b_en_o        = cfg_q[17];
    assign lane0_en_o         = cfg_q[16];
    assign lane1_en_o         = cfg_q[15];
    assign octets_per_frame_o = cfg_q[14:12];
    assign high_density_o     = cfg_q[11];
    assign frames_per_multi_o = cfg_q[10:6];
    assign converters_o       = cfg_q[5:4];
    assign lanes_o            = cfg_q[3:2];
    assign loop_test_o        = cfg_q[1];
    assign power_down_o       = cfg_q[0];
    // framing constants common to every setup
    assign ctrl_bits_o        = 1'b1;
    assign ctrl_words_o       = 1'b0;
    assign samples_o          = 1'b1;

    assign internal_reference_enable_o =
        ref_ctrl_q[`ADCR_REF_EN_BIT];
    assign reference_attenuation_o = ref_ctrl_q[2:0];
    assign sync_single_ended_o     = link_ctrl_q[0];
    assign spi_sdio_o              = sdo_q;
    assign spi_sdio_oe_o           = sdo_oe_q;

    // offset trim with clamping; offset-binary codes assumed
    function [11:0] trim;
        input [11:0] d;
        input [5:0]  o;
        reg   [13:0] s;
        begin
            s = {2'b00, d} + {{8{o[5]}}, o};
            if (s[13])
                trim = 12'h000;
            else if (s[12])
                trim = 12'hfff;
            else
                trim = s[11:0];
        end
    endfunction

    // test pattern generator; toggle flips on each sample
    reg        toggle_q;
    reg [11:0] pat;
    always @* begin
        case (pat_sel_q)
            `ADCR_PAT_MID:    pat = `ADCR_CODE_MID;
            `ADCR_PAT_NEG_FS: pat = `ADCR_CODE_NEG_FS;
            `ADCR_PAT_POS_FS: pat = `ADCR_CODE_POS_FS;
            `ADCR_PAT_TOGGLE: pat = toggle_q ? `ADCR_CODE_POS_FS :
                                               `ADCR_CODE_NEG_FS;
            `ADCR_PAT_CUSTOM: pat = {pat_high_q, pat_low_q};
            `ADCR_PAT_0101:   pat = `ADCR_CODE_0101;
            `ADCR_PAT_1010:   pat = `ADCR_CODE_1010;
            default:          pat = 12'h000;
        endcase
    end

    // output samples, pattern replaces data unless select is off
    reg [11:0] out_a_q;
    reg [11:0] out_b_q;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_a_q  <= 12'h000;
            out_b_q  <= 12'h000;
            toggle_q <= 1'b0;
        end else if (sample_en_i) begin
            toggle_q <= ~toggle_q;
            if (pat_sel_q == `ADCR_PAT_OFF) begin
                out_a_q <= trim(adc_a_data_i, offset_q);
                out_b_q <= trim(adc_b_data_i, offset_q);
            end else begin
                out_a_q <= pat;
                out_b_q <= pat;
            end
        end
    end
    assign out_a_data_o = out_a_q;
    assign out_b_data_o = out_b_q;

endmodule // adcr_regs

/* File: logic/adcr_consts.vh */
// adcr_consts.vh: addresses, fields, reset values and codes of the
// converter configuration register bank.
// assumes: included by the register bank and its bench, by bare name.
`ifndef ADCR_CONSTS_VH
`define ADCR_CONSTS_VH

// register addresses on the 13-bit serial address space
`define ADCR_ADDR_REF_CTRL      13'h0008
`define ADCR_ADDR_OFFSET_TRIM   13'h0013
`define ADCR_ADDR_PAT_SELECT    13'h0014
`define ADCR_ADDR_PAT_HIGH      13'h0015
`define ADCR_ADDR_PAT_LOW       13'h0016
`define ADCR_ADDR_LINK_STATUS   13'h0801
`define ADCR_ADDR_LINK_RESET    13'h0802
`define ADCR_ADDR_QUICK_SETUP   13'h0803
`define ADCR_ADDR_LINK_CTRL     13'h0805

// field positions
`define ADCR_REF_EN_BIT         3
`define ADCR_SYNC_ERR_BIT       7
`define ADCR_POR_BIT            1
`define ADCR_UNIT_RST_BIT       7
`define ADCR_FSM_RST_BIT        3
`define ADCR_SYNC_INPUT_POLARITY_BIT       5
`define ADCR_SYNC_SE_BIT        4

// reset values and fixed read fields
`define ADCR_RST_BYTE           8'h00
`define ADCR_STATUS_RSVD        3'h2
`define ADCR_LINK_CTRL_RST      8'h08

// test pattern select codes
`define ADCR_PAT_OFF            3'h0
`define ADCR_PAT_MID            3'h1
`define ADCR_PAT_NEG_FS         3'h2
`define ADCR_PAT_POS_FS         3'h3
`define ADCR_PAT_TOGGLE         3'h4
`define ADCR_PAT_CUSTOM         3'h5
`define ADCR_PAT_0101           3'h6
`define ADCR_PAT_1010           3'h7

// output code values of the fixed patterns
`define ADCR_CODE_MID           12'h800
`define ADCR_CODE_NEG_FS        12'h000
`define ADCR_CODE_POS_FS        12'hfff
`define ADCR_CODE_0101          12'h555
`define ADCR_CODE_1010          12'haaa

// serial frame: 1 direction bit, 2 length bits, 13 address bits, 8 data
`define ADCR_HDR_BITS           5'd16
`define ADCR_FRAME_BITS         5'd24

`endif

/* File: logic/adcr_sync3.v */
// adcr_sync3.v: three-flop pin synchroniser, one lane per bit.
// assumes: inputs are asynchronous pins; output follows a bit only once
// the second and third flops agree on it.
`timescale 1ns/1ps

module adcr_sync3 #(
    parameter           W       = 1,
    parameter [W-1:0]   RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input  wire         core_clk_i,
    input  wire         rst_i,
    // asynchronous in, qualified out
    input  wire [W-1:0] pin_i,
    output wire [W-1:0] sync_o
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_lane
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg out_q;
            // first flop feeds only the second one
            always @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    s1_q  <= RST_VAL[g];
                    s2_q  <= RST_VAL[g];
                    s3_q  <= RST_VAL[g];
                    out_q <= RST_VAL[g];
                end else begin
                    s1_q <= pin_i[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        out_q <= s3_q;
                end
            end
            assign sync_o[g] = out_q;
        end
    endgenerate

endmodule // adcr_sync3

/* File: verif/adcr_regs_monitor.sv */
// adcr_regs_monitor.sv: port assertions for the converter register bank.
// assumes: bound to adcr_regs; core_clk_i is the only clock domain.
`timescale 1ns/1ps

module adcr_regs_monitor (
    // clock, reset and sample strobe
    input wire        core_clk_i, rst_i, sample_en_i,
    // sample outputs and link resets
    input wire [11:0] out_a_data_o, out_b_data_o,
    input wire        link_unit_reset_o, link_fsm_reset_o,
    // decoded link setup
    input wire        conv_a_en_o, conv_b_en_o, lane0_en_o, lane1_en_o,
    input wire [2:0]  octets_per_frame_o,
    input wire        high_density_o, loop_test_o, power_down_o,
    input wire [4:0]  frames_per_multi_o,
    input wire [1:0]  converters_o, lanes_o,
    input wire        ctrl_bits_o, ctrl_words_o, samples_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // framing fields never depend on the setup
    AST_FIXED: assert property (
        ctrl_bits_o && !ctrl_words_o && samples_o)
        else $error("fixed framing wrong");
    AST_BOTH_LANES: assert property (
        lane0_en_o && lane1_en_o |-> lanes_o == 2'd2)
        else $error("lane count not two");
    AST_BOTH_CONV: assert property (
        conv_a_en_o && conv_b_en_o && lane0_en_o && lane1_en_o |->
        converters_o == 2'd2 && octets_per_frame_o == 3'd2 &&
        frames_per_multi_o == 5'd9 && !high_density_o)
        else $error("full setup framing wrong");
    // a single lane carries either both converters or just one
    AST_ONE_LANE: assert property (
        lane0_en_o != lane1_en_o |-> lanes_o == 2'd1 &&
        (conv_a_en_o && conv_b_en_o ?
         octets_per_frame_o == 3'd4 && frames_per_multi_o == 5'd5 :
         octets_per_frame_o == 3'd2 && frames_per_multi_o == 5'd9 &&
         converters_o == 2'd1 && conv_a_en_o != conv_b_en_o))
        else $error("single lane framing wrong");
    AST_HIGH_DENS: assert property (
        high_density_o |-> octets_per_frame_o == 3'd1 &&
        frames_per_multi_o == 5'd17 && converters_o == 2'd1 &&
        conv_a_en_o != conv_b_en_o && lane0_en_o && lane1_en_o)
        else $error("high density framing wrong");
    AST_LOOP: assert property (
        loop_test_o |-> conv_a_en_o && conv_b_en_o && lane0_en_o &&
        lane1_en_o && !power_down_o)
        else $error("loop test not fully on");
    AST_PDOWN: assert property (
        power_down_o |-> !(conv_a_en_o || conv_b_en_o || lane0_en_o ||
        lane1_en_o) && converters_o == 2'd2 && lanes_o == 2'd2)
        else $error("power-down leaves a unit on");
    AST_UNIT_PULSE: assert property (
        $rose(link_unit_reset_o) |-> ##1 !link_unit_reset_o [*3])
        else $error("unit reset not one pulse");
    AST_FSM_PULSE: assert property (
        link_fsm_reset_o |=> !link_fsm_reset_o)
        else $error("fsm reset not one pulse");
    // outputs move only on a sample strobe
    AST_OUT_HOLD: assert property (
        !$past(sample_en_i) |-> $stable(out_a_data_o) &&
        $stable(out_b_data_o))
        else $error("output moved without strobe");
endmodule // adcr_regs_monitor

bind adcr_regs adcr_regs_monitor u_mon (.*);

/* File: verif/adcr_spi_host.sv */
// adcr_spi_host.sv: behavioural serial host that configures the bank.
// assumes: sdio_i is the resolved data wire; core clock paces the bits.
`timescale 1ns/1ps

module adcr_spi_host (
    // pacing clock
    input  wire  core_clk_i,
    // serial port, host side
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdo_o,
    input  wire  sdio_i
);
    // 480 ns half period, well over 160 ns
    localparam int HALF = 12;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdo_o  = 1'b0;
    end

    // one frame: direction, length bits, address, one data byte
    task automatic xfer(input logic rw, input logic [12:0] a,
                        input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] fr;
        fr = {rw, 2'b00, a, wd};
        @(posedge core_clk_i) cs_n_o <= 1'b0;
        repeat (HALF) @(posedge core_clk_i);
        for (int i = 23; i >= 0; i--) begin
            // read data bits: host keeps driving but toggles its bit, so an undriven line is not stale
            sdo_o <= (rw && i < 8) ? ~sdo_o : fr[i];
            repeat (HALF) @(posedge core_clk_i);
            sclk_o <= 1'b1;
            rd = {rd[6:0], sdio_i};
            repeat (HALF) @(posedge core_clk_i);
            sclk_o <= 1'b0;
        end
        repeat (HALF) @(posedge core_clk_i);
        cs_n_o <= 1'b1;
        sdo_o  <= ~sdo_o;
        repeat (HALF) @(posedge core_clk_i);
    endtask
endmodule // adcr_spi_host

/* File: verif/adcr_regs_bench.sv */
// adcr_regs_bench.sv: self-checking bench for the register bank.
// assumes: serial host model on the port; one 25 MHz core clock.
`timescale 1ns/1ps
`include "adcr_consts.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module adcr_regs_bench;
    logic        clk = 1'b0, rst = 1'b1, sample_en = 1'b0, sync = 1'b1;
    logic [11:0] adc_a = 12'h000, adc_b = 12'h000, t;
    wire         sclk, cs_n, h_sdo, d_sdo, d_oe, ref_en, unit_rst, fsm_rst;
    wire         se, ca, cb, l0, l1, hd, loopt, pd;
    wire [11:0]  out_a, out_b;
    wire [2:0]   atten, f;
    wire [4:0]   k;
    wire [1:0]   m, l;
    wire         sdio_w = d_oe ? d_sdo : h_sdo; // resolved data wire
    wire [18:0]  dec = {ca, cb, l0, l1, f, hd, k, m, l, loopt, pd};
    int          n_fail = 0, checked = 0, cyc = 0, n_unit = 0, n_fsm = 0;
    logic [11:0] pexp [8] = '{0, `ADCR_CODE_MID, `ADCR_CODE_NEG_FS,
        `ADCR_CODE_POS_FS, 0, 12'habc, `ADCR_CODE_0101, `ADCR_CODE_1010};
    localparam logic [14:0] F2K9 = {3'd2, 1'b0, 5'd9, 2'd2, 2'd2, 2'b00};

    adcr_regs u_dut (.core_clk_i(clk), .rst_i(rst), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_sdio_i(sdio_w), .spi_sdio_o(d_sdo),
        .spi_sdio_oe_o(d_oe), .cfg_pins_i(4'h3), .link_sync_i(sync),
        .sample_en_i(sample_en), .adc_a_data_i(adc_a), .adc_b_data_i(adc_b),
        .out_a_data_o(out_a), .out_b_data_o(out_b),
        .internal_reference_enable_o(ref_en), .reference_attenuation_o(atten),
        .link_unit_reset_o(unit_rst), .link_fsm_reset_o(fsm_rst),
        .sync_single_ended_o(se), .conv_a_en_o(ca), .conv_b_en_o(cb),
        .lane0_en_o(l0), .lane1_en_o(l1), .octets_per_frame_o(f),
        .high_density_o(hd), .frames_per_multi_o(k), .converters_o(m),
        .lanes_o(l), .ctrl_bits_o(), .ctrl_words_o(), .samples_o(),
        .loop_test_o(loopt), .power_down_o(pd));
    adcr_spi_host u_host (.core_clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
        .sdo_o(h_sdo), .sdio_i(sdio_w));

    always #20 clk = ~clk;
    // pulse counters and hang guard
    always @(posedge clk) begin
        cyc++;
        if (unit_rst === 1'b1) n_unit++;
        if (fsm_rst === 1'b1) n_fsm++;
        if (cyc == 60000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer(1'b0, a, d, r);
    endtask
    task automatic rchk(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] r;
        u_host.xfer(1'b1, a, 8'h00, r);
        `CHK(r, e)
    endtask
    task automatic pulse(input logic [11:0] a);
        @(posedge clk) {adc_a, adc_b, sample_en} <= {a, a, 1'b1};
        @(posedge clk) sample_en <= 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic smp(input logic [11:0] a, input logic [11:0] e);
        pulse(a);
        `CHK(out_a, e)
        `CHK(out_b, e)
    endtask
    // expected decode {a, b, lane0, lane1, F, HD, K, M, L, loop, pd}
    function automatic logic [18:0] sexp(input logic [3:0] c);
        case (c)
            4'h0: return {4'b1111, F2K9};
            4'h1, 4'h2: return {2'b11, ~c[1], c[1],
                                3'd4, 1'b0, 5'd5, 2'd2, 2'd1, 2'b00};
            4'h3, 4'h4: return {~c[2], c[2], 2'b11,
                                3'd1, 1'b1, 5'd17, 2'd1, 2'd2, 2'b00};
            4'he: return {4'b1111, F2K9 | 15'h2};
            4'hf: return {4'b0000, F2K9 | 15'h1};
            default: return {c < 4'h7, c > 4'h6, c[0], ~c[0],
                             3'd2, 1'b0, 5'd9, 2'd1, 2'd1, 2'b00};
        endcase
    endfunction

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        rchk(`ADCR_ADDR_PAT_HIGH, 8'h00);
        rchk(`ADCR_ADDR_LINK_RESET, 8'h00);
        rchk(`ADCR_ADDR_LINK_STATUS, 8'h22);
        wr(13'h0100, 8'hff);
        rchk(13'h0100, 8'h00);
        $display("test reset_and_unmapped done");
        `CHK({hd, ca, cb}, 3'b110)
        for (int c = 0; c < 16; c++) if (c < 9 || c > 13) begin
            wr(`ADCR_ADDR_QUICK_SETUP, 8'(c));
            `CHK(dec, sexp(4'(c)))
            rchk(`ADCR_ADDR_QUICK_SETUP, 8'(c));
        end
        $display("test quick_setup done");
        wr(`ADCR_ADDR_REF_CTRL, 8'h0e);
        `CHK({ref_en, atten}, 4'he)
        wr(`ADCR_ADDR_REF_CTRL, 8'h07);
        `CHK({ref_en, atten}, 4'h7)
        wr(`ADCR_ADDR_PAT_HIGH, 8'hab);
        wr(`ADCR_ADDR_PAT_LOW, 8'hc5); // low nibble must be ignored
        for (int s = 1; s < 8; s++) if (s != 4) begin
            wr(`ADCR_ADDR_PAT_SELECT, 8'(s));
            smp(12'h123, pexp[s]);
        end
        wr(`ADCR_ADDR_PAT_SELECT, 8'h04);
        pulse(12'h123);
        t = out_a;
        pulse(12'h123);
        `CHK(out_a ^ t, 12'hfff)
        `CHK(t == 12'h000 || t == 12'hfff, 1'b1)
        wr(`ADCR_ADDR_PAT_SELECT, 8'h00);
        wr(`ADCR_ADDR_OFFSET_TRIM, 8'h1f);
        smp(12'h123, 12'h142);
        smp(12'hff0, 12'hfff);
        wr(`ADCR_ADDR_OFFSET_TRIM, 8'h20);
        smp(12'h123, 12'h103);
        smp(12'h010, 12'h000);
        $display("test datapath done");
        // active-low sync goes active after idling high
        @(posedge clk) sync <= 1'b0;
        repeat (8) @(posedge clk);
        sync <= 1'b1;
        rchk(`ADCR_ADDR_LINK_STATUS, 8'ha2);
        wr(`ADCR_ADDR_LINK_RESET, 8'h80);
        `CHK(n_unit, 1)
        rchk(`ADCR_ADDR_LINK_STATUS, 8'h20);
        wr(`ADCR_ADDR_LINK_RESET, 8'h08);
        `CHK(n_unit, 1)
        `CHK(n_fsm, 2)
        rchk(`ADCR_ADDR_LINK_RESET, 8'h00);
        // polarity flipped: now only a high level is active
        wr(`ADCR_ADDR_LINK_CTRL, 8'h30);
        `CHK(se, 1'b1)
        @(posedge clk) sync <= 1'b0;
        wr(`ADCR_ADDR_LINK_RESET, 8'h80);
        rchk(`ADCR_ADDR_LINK_STATUS, 8'h20);
        @(posedge clk) sync <= 1'b1;
        repeat (8) @(posedge clk);
        rchk(`ADCR_ADDR_LINK_STATUS, 8'ha0);
        $display("test link_control done");
        final_report();
    end
endmodule // adcr_regs_bench
